/* File: verilog/ucr_uart_top.sv */
// What this block does
// - Parity inhibit: no parity, parity error low.
// - Inhibited parity: stop bits follow data.
// - Even select bit chooses even else odd.
// - Two length bits give five to eight bits.
// - Stop select: one, one-and-half, or two.
// - Interrupt enable gates all interrupt sources.
// - Break bit forces serial output low.
// - Low holds until clear, CTS high, word.
// - Request bit drives request-to-send low.
// - Control write with request changes only request.
// - Holding register captured at strobe trailing edge.
// - Shift loads on falling edge, start later.
// - Register select picks control or holding register.
// - Clear resets control, sets serial output high.
// - Unused high bits are never transmitted.
//
// Processor-side control register and transmit load logic of the UART.
// Assumes the processor pins and the serial clock pin are asynchronous to
// i_ref_clk, which must run well above twice the serial clock rate.
`timescale 1ns/1ps
`default_nettype none
module ucr_uart_top #(
    parameter int CLKS_PER_BIT = ucr_pkg::TX_CLKS_PER_BIT
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_tx_bus,
    input wire logic i_chip_sel_a,
    input wire logic i_chip_sel_b,
    input wire logic i_chip_sel_c,
    input wire logic i_read_not_write,
    input wire logic i_register_select,
    input wire logic i_write_strobe,
    input wire logic i_clear_b,
    input wire logic i_cts_b,
    input wire logic i_ser_clk,
    input wire logic i_periph_status_irq_b,
    input wire logic i_rx_char_ready,
    input wire logic i_rx_parity_fail,
    output logic o_serial_out,
    output logic o_rts_b,
    output logic o_holding_reg_empty_b,
    output logic o_shift_reg_empty,
    output logic o_int_b,
    output logic o_parity_error,
    output logic [4:0] o_rx_format
);
    import ucr_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [7:0] lat_bus;
        logic lat_cs;
        logic lat_rnw;
        logic lat_register_select;
        logic [7:0] ctl;
        logic brk_hold;
        logic [7:0] thr;
        logic thr_full;
        logic armed;
        logic holding_reg_empty_pend;
        logic cts_pend;
        logic psi_pend;
        logic serial_out;
        logic rts_b;
        logic holding_reg_empty_b;
        logic shift_reg_empty;
        logic int_b;
        logic parity_error;
        logic [4:0] rx_format;
    } ucr_top_t;

    localparam ucr_top_t TOP_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, lat_bus: 8'h00,
        lat_cs: 1'b0, lat_rnw: 1'b0, lat_register_select: 1'b0, ctl: CTL_RESET, brk_hold: 1'b0,
        thr: 8'h00, thr_full: 1'b0, armed: 1'b0, holding_reg_empty_pend: 1'b0, cts_pend: 1'b0,
        psi_pend: 1'b0, serial_out: 1'b1, rts_b: 1'b1, holding_reg_empty_b: 1'b0, shift_reg_empty: 1'b1,
        int_b: 1'b1, parity_error: 1'b0, rx_format: 5'h00};

    ucr_top_t r, n;
    logic [PIN_W-1:0] pin_raw;
    logic strb_fall, sclk_fall, sclk_rise, clr_act;
    logic wr_ctl, wr_thr, rd_stat;

    ucr_tx_if tx_if ();

    ucr_tx_shift #(
        .CLKS_PER_BIT(CLKS_PER_BIT)
    ) ucr_tx_shift_inst (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .tx(tx_if.shift)
    );

    always_comb begin
        pin_raw = '0;
        pin_raw[PIN_BUS +: 8] = i_tx_bus;
        pin_raw[PIN_CSA] = i_chip_sel_a;
        pin_raw[PIN_CSB] = i_chip_sel_b;
        pin_raw[PIN_CSC] = i_chip_sel_c;
        pin_raw[PIN_RNW] = i_read_not_write;
        pin_raw[PIN_REGISTER_SELECT] = i_register_select;
        pin_raw[PIN_STRB] = i_write_strobe;
        pin_raw[PIN_CLR] = i_clear_b;
        pin_raw[PIN_CTS] = i_cts_b;
        pin_raw[PIN_SCLK] = i_ser_clk;
        pin_raw[PIN_PSI] = i_periph_status_irq_b;
    end

    // Edges are taken between the second and third stages only.
    assign strb_fall = r.s3[PIN_STRB] & ~r.s2[PIN_STRB];
    assign sclk_fall = r.s3[PIN_SCLK] & ~r.s2[PIN_SCLK];
    assign sclk_rise = ~r.s3[PIN_SCLK] & r.s2[PIN_SCLK];
    assign clr_act = ~r.s2[PIN_CLR];
    assign wr_ctl = strb_fall & r.lat_cs & ~r.lat_rnw & r.lat_register_select;
    assign wr_thr = strb_fall & r.lat_cs & ~r.lat_rnw & ~r.lat_register_select;
    assign rd_stat = strb_fall & r.lat_cs & r.lat_rnw & r.lat_register_select;

    assign tx_if.load = r.thr_full & r.armed & sclk_fall & ~r.s2[PIN_CTS] & ~tx_if.busy & ~clr_act;
    assign tx_if.abort = clr_act;
    assign tx_if.sclk_rise = sclk_rise;
    assign tx_if.data = r.thr;
    assign tx_if.wlen = {r.ctl[CTL_WL_HI], r.ctl[CTL_WL_LO]};
    assign tx_if.no_par = r.ctl[CTL_NO_PAR];
    assign tx_if.even = r.ctl[CTL_EVEN];
    assign tx_if.stop_sel = r.ctl[CTL_STOP];

    always_comb begin
        n = r;
        n.s1 = pin_raw;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // Bus and selects are held from the last sample with the strobe high,
        // so the write uses values that met setup to the trailing edge.
        if (r.s2[PIN_STRB]) begin
            n.lat_bus = r.s2[PIN_BUS +: 8];
            n.lat_cs = r.s2[PIN_CSA] & ~r.s2[PIN_CSB] & r.s2[PIN_CSC];
            n.lat_rnw = r.s2[PIN_RNW];
            n.lat_register_select = r.s2[PIN_REGISTER_SELECT];
        end
        if (wr_ctl) begin
            if (r.lat_bus[CTL_REQ]) begin
                n.ctl[CTL_REQ] = 1'b1;
                if (!r.ctl[CTL_REQ] && !r.thr_full) begin
                    n.holding_reg_empty_pend = 1'b1;
                end
            end else begin
                n.ctl = r.lat_bus;
            end
        end
        if (r.thr_full && sclk_rise) begin
            n.armed = 1'b1;
        end
        if (tx_if.load) begin
            n.thr_full = 1'b0;
            n.armed = 1'b0;
            n.holding_reg_empty_pend = r.ctl[CTL_REQ];
        end
        // capture on trailing edge
        // A write that lands in the load cycle keeps its character, and the empty flag still sets when the request bit is set.
        if (wr_thr) begin
            n.thr = r.lat_bus;
            n.thr_full = 1'b1;
            n.armed = 1'b0;
            if (!tx_if.load) begin
                n.holding_reg_empty_pend = 1'b0;
            end
        end
        // A status read clears the edge flags, but a new edge in that cycle wins.
        if (rd_stat) begin
            n.cts_pend = 1'b0;
            n.psi_pend = 1'b0;
        end
        if (r.s2[PIN_CTS] != r.s3[PIN_CTS]) begin
            n.cts_pend = 1'b1;
        end
        if (r.s3[PIN_PSI] && !r.s2[PIN_PSI]) begin
            n.psi_pend = 1'b1;
        end
        if (r.ctl[CTL_BRK]) begin
            n.brk_hold = 1'b1;
        end else if (r.s2[PIN_CTS] || tx_if.done) begin
            n.brk_hold = 1'b0;
        end
        if (clr_act) begin
            n.ctl = CTL_RESET;
            n.brk_hold = 1'b0;
            n.thr_full = 1'b0;
            n.armed = 1'b0;
            n.holding_reg_empty_pend = 1'b0;
            n.cts_pend = 1'b0;
            n.psi_pend = 1'b0;
        end
        n.serial_out = clr_act | (tx_if.line & ~n.ctl[CTL_BRK] & ~n.brk_hold);
        n.rts_b = ~n.ctl[CTL_REQ];
        n.holding_reg_empty_b = n.thr_full;
        // Falls with the load, so an idle shifter and an empty holding register never show together mid-stream.
        n.shift_reg_empty = ~tx_if.busy & ~tx_if.load;
        n.int_b = ~(n.ctl[CTL_IRQ] & (n.holding_reg_empty_pend | i_rx_char_ready | n.cts_pend | n.psi_pend));
        n.parity_error = i_rx_parity_fail & ~n.ctl[CTL_NO_PAR];
        n.rx_format = n.ctl[CTL_WL_HI:CTL_NO_PAR];
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            r <= TOP_RST;
        end else begin
            r <= n;
        end
    end

    assign o_serial_out = r.serial_out;
    assign o_rts_b = r.rts_b;
    assign o_holding_reg_empty_b = r.holding_reg_empty_b;
    assign o_shift_reg_empty = r.shift_reg_empty;
    assign o_int_b = r.int_b;
    assign o_parity_error = r.parity_error;
    assign o_rx_format = r.rx_format;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    pe_inhibit_a: assert property (r.ctl[CTL_NO_PAR] |-> !o_parity_error)
        else $error("parity error shown while parity inhibited");
    irq_gate_a: assert property (!r.ctl[CTL_IRQ] |-> o_int_b)
        else $error("interrupt asserted while disabled");
    break_low_a: assert property (r.ctl[CTL_BRK] |-> !o_serial_out)
        else $error("serial output high during break");
    break_hold_a: assert property ((r.brk_hold && !r.ctl[CTL_BRK] && !clr_act && !r.s2[PIN_CTS]
        && !tx_if.done) |=> !o_serial_out) else $error("break released early");
    rts_follow_a: assert property ((wr_ctl && r.lat_bus[CTL_REQ] && !clr_act) |=>
        (!o_rts_b && r.ctl[CTL_REQ])) else $error("request-to-send not asserted");
    req_only_a: assert property ((wr_ctl && r.lat_bus[CTL_REQ] && !clr_act) |=>
        (r.ctl[6:0] == $past(r.ctl[6:0]))) else $error("format changed by request write");
    thr_capture_a: assert property ((wr_thr && !clr_act) |=>
        (r.thr == $past(r.lat_bus) && o_holding_reg_empty_b)) else $error("holding register not captured");
    load_edge_a: assert property (tx_if.load |-> (sclk_fall && r.armed && !r.s2[PIN_CTS]))
        else $error("shift load off a falling edge");
    clear_reset_a: assert property (clr_act |=> (o_serial_out && r.ctl == CTL_RESET))
        else $error("clear did not reset");

    ctl_write_c: cover property (wr_ctl ##[1:200] wr_ctl);
    tx_load_c: cover property (wr_thr ##[1:300] tx_if.load);
    break_release_c: cover property (r.brk_hold && !r.ctl[CTL_BRK] ##1 !r.brk_hold);
endmodule
`default_nettype wire

/* File: shared/ucr_pkg.sv */
// Constants and types for the serial format control and transmit load block.
// Assumes a single reference clock; every pin is sampled through two flip-flops.
package ucr_pkg;
    // Bit positions of the sampled pin vector.
    localparam int PIN_BUS = 0;
    localparam int PIN_CSA = 8;
    localparam int PIN_CSB = 9;
    localparam int PIN_CSC = 10;
    localparam int PIN_RNW = 11;
    localparam int PIN_REGISTER_SELECT = 12;
    localparam int PIN_STRB = 13;
    localparam int PIN_CLR = 14;
    localparam int PIN_CTS = 15;
    localparam int PIN_SCLK = 16;
    localparam int PIN_PSI = 17;
    localparam int PIN_W = 18;
    // Idle pin levels: clear, clear-to-send and peripheral status are high when quiet.
    localparam logic [PIN_W-1:0] PIN_IDLE = 18'h2c000;

    // Field positions of serial_format_control.
    localparam int CTL_NO_PAR = 0;
    localparam int CTL_EVEN = 1;
    localparam int CTL_STOP = 2;
    localparam int CTL_WL_LO = 3;
    localparam int CTL_WL_HI = 4;
    localparam int CTL_IRQ = 5;
    localparam int CTL_BRK = 6;
    localparam int CTL_REQ = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Serial clocks per transmitted bit.
    localparam int TX_CLKS_PER_BIT = 16;
    // Word length code 00 means this many data bits, less one.
    localparam logic [2:0] WLEN_BASE_M1 = 3'h4;

    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} ucr_tx_state_t;
endpackage

/* File: shared/ucr_tx_if.sv */
// Link between the control side and the transmit shifter.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none
interface ucr_tx_if;
    logic load;
    logic abort;
    logic sclk_rise;
    logic [7:0] data;
    logic [1:0] wlen;
    logic no_par;
    logic even;
    logic stop_sel;
    logic busy;
    logic line;
    logic done;
    modport ctrl (output load, abort, sclk_rise, data, wlen, no_par, even, stop_sel, input busy, line, done);
    modport shift (input load, abort, sclk_rise, data, wlen, no_par, even, stop_sel, output busy, line, done);
endinterface
`default_nettype wire

/* File: verilog/ucr_tx_shift.sv */
// Transmit shift register: frames one character per load on serial clock edges.
// Assumes load arrives on a serial clock falling edge and sclk_rise marks rising edges.
`timescale 1ns/1ps
`default_nettype none
module ucr_tx_shift #(
    parameter int CLKS_PER_BIT = ucr_pkg::TX_CLKS_PER_BIT
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    ucr_tx_if.shift tx
);
    import ucr_pkg::*;

    typedef struct packed {
        ucr_tx_state_t st;
        logic [7:0] cnt;
        logic [2:0] idx;
        logic [7:0] sr;
        logic par;
        logic line;
        logic busy;
        logic done;
    } ucr_shift_t;

    localparam ucr_shift_t SHIFT_RST = '{st: TX_IDLE, cnt: 8'h00, idx: 3'h0, sr: 8'h00,
                                         par: 1'b0, line: 1'b1, busy: 1'b0, done: 1'b0};
    localparam logic [7:0] BIT_END = 8'(CLKS_PER_BIT - 1);
    // The stop bit is cut one serial clock short so that a waiting character's
    // load edge and start edge land exactly where the last stop bit ends.
    localparam logic [7:0] STOP1_END = 8'(CLKS_PER_BIT - 2);
    localparam logic [7:0] STOP15_END = 8'(CLKS_PER_BIT * 3 / 2 - 2);
    localparam logic [7:0] STOP2_END = 8'(CLKS_PER_BIT * 2 - 2);

    generate
        if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 126 || CLKS_PER_BIT % 2 != 0) begin : g_bad
            $error("CLKS_PER_BIT must be even and within 4 to 126");
        end
    endgenerate

    ucr_shift_t r, n;
    logic [2:0] last_bit;
    logic [7:0] mask;
    logic [7:0] stop_end;

    assign last_bit = WLEN_BASE_M1 + {1'b0, tx.wlen};

    generate
        for (genvar i = 0; i < 8; i++) begin : g_mask
            assign mask[i] = (3'(i) <= last_bit);
        end
    endgenerate

    always_comb begin
        if (!tx.stop_sel) begin
            stop_end = STOP1_END;
        end else if (tx.wlen == 2'h0) begin
            stop_end = STOP15_END;
        end else begin
            stop_end = STOP2_END;
        end
    end

    always_comb begin
        n = r;
        n.done = 1'b0;
        if (tx.abort) begin
            n = SHIFT_RST;
        end else if (tx.load && !r.busy) begin
            n.sr = tx.data & mask;
            n.par = tx.even ? ^(tx.data & mask) : ~^(tx.data & mask);
            n.st = TX_WAIT;
            n.busy = 1'b1;
            n.idx = 3'h0;
        end else if (tx.sclk_rise) begin
            n.cnt = r.cnt + 8'h01;
            case (r.st)
                TX_WAIT: begin
                    n.st = TX_START;
                    n.line = 1'b0;
                    n.cnt = 8'h00;
                end
                TX_START: begin
                    if (r.cnt == BIT_END) begin
                        n.st = TX_DATA;
                        n.line = r.sr[0];
                        n.cnt = 8'h00;
                    end
                end
                TX_DATA: begin
                    if (r.cnt == BIT_END) begin
                        n.cnt = 8'h00;
                        if (r.idx == last_bit) begin
                            n.st = tx.no_par ? TX_STOP : TX_PAR;
                            n.line = tx.no_par ? 1'b1 : r.par;
                        end else begin
                            n.idx = r.idx + 3'h1;
                            n.sr = {1'b0, r.sr[7:1]};
                            n.line = r.sr[1];
                        end
                    end
                end
                TX_PAR: begin
                    if (r.cnt == BIT_END) begin
                        n.st = TX_STOP;
                        n.line = 1'b1;
                        n.cnt = 8'h00;
                    end
                end
                TX_STOP: begin
                    if (r.cnt == stop_end) begin
                        n.st = TX_IDLE;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                    end
                end
                default: begin
                    n.cnt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            r <= SHIFT_RST;
        end else begin
            r <= n;
        end
    end

    assign tx.busy = r.busy;
    assign tx.line = r.line;
    assign tx.done = r.done;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    start_edge_a: assert property ((tx.sclk_rise && r.st == TX_WAIT && !tx.abort) |=>
        (r.st == TX_START && !r.line)) else $error("start bit did not begin on rise");
    no_par_skip_a: assert property ((r.st == TX_DATA && tx.no_par && !tx.abort) |-> ##1
        (r.st != TX_PAR)) else $error("parity bit sent while inhibited");
    len_bound_a: assert property ((r.st == TX_DATA) |-> (r.idx <= last_bit))
        else $error("data bit beyond word length");
    par_value_a: assert property ((r.st == TX_PAR) |-> (r.line == r.par))
        else $error("parity bit level wrong");
endmodule
`default_nettype wire

/* File: verification/ucr_host_model.sv */
// Processor bus model that performs write cycles on the device pins.
// Assumes pins change on the falling edge of the reference clock.
`timescale 1ns/1ps
`default_nettype none
module ucr_host_model (
    input wire logic i_ref_clk,
    output logic [7:0] o_bus,
    output logic o_cs_a,
    output logic o_cs_b,
    output logic o_cs_c,
    output logic o_rnw,
    output logic o_register_select,
    output logic o_strobe
);
    // A released bus shows the inverse of its last value, so a stale value can never look valid.
    task automatic release_bus();
        o_cs_a = 1'b0;
        o_cs_b = 1'b1;
        o_cs_c = 1'b0;
        o_rnw = 1'b1;
        o_register_select = ~o_register_select;
        o_bus = ~o_bus;
    endtask

    initial begin
        o_bus = 8'h00;
        o_register_select = 1'b0;
        o_strobe = 1'b0;
        release_bus();
    end

    task automatic write(input logic register_select, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_cs_a = 1'b1;
        o_cs_b = 1'b0;
        o_cs_c = 1'b1;
        o_rnw = 1'b0;
        o_register_select = register_select;
        o_bus = d;
        o_strobe = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        o_strobe = 1'b0;
        // Selects outlive the strobe because the device sees the strobe through synchronisers.
        repeat (3) @(negedge i_ref_clk);
        release_bus();
        repeat (4) @(negedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: verification/test_uart_control_and_tx_load.sv */
// Self-checking bench for the control register and transmit load block.
// Assumes the host model drives the bus and the bench drives the serial clock.
`timescale 1ns/1ps
`default_nettype none
module test_uart_control_and_tx_load;
    localparam int CPB = 4;
    localparam int BIT = CPB * 8;
    localparam logic [7:0] CTL_TAB [8] = '{8'h00, 8'h07, 8'h0a, 8'h0c, 8'h12, 8'h15, 8'h1a, 8'h1c};
    localparam logic [7:0] DAT_TAB [8] = '{8'he5, 8'hff, 8'h96, 8'h2d, 8'hc3, 8'h5a, 8'h69, 8'hb4};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clear_b = 1'b1;
    logic cts_b = 1'b0;
    logic ser_clk = 1'b0;
    logic rx_pfail = 1'b0;
    logic rx_rdy = 1'b0;
    logic psi_b = 1'b1;
    logic rec = 1'b0;
    logic [1:0] sc_cnt = 2'h0;
    logic line_q[$];
    logic [7:0] tx_bus;
    logic cs_a, cs_b, cs_c, rnw, register_select, strb;
    logic so, rts_b, hre_b, sre, int_b, perr;
    logic [4:0] rxf;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int k;

    always #12.5 clk = ~clk;

    // The serial clock toggles every four reference cycles, inside the sampler's limits.
    always @(negedge clk) begin
        sc_cnt <= sc_cnt + 2'h1;
        if (sc_cnt == 2'h3) ser_clk <= ~ser_clk;
    end

    // The line is sampled mid-cycle, away from the edge that launches it.
    always @(negedge clk) begin
        if (rec) line_q.push_back(so);
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    ucr_host_model ucr_host_model_inst (.i_ref_clk(clk), .o_bus(tx_bus), .o_cs_a(cs_a), .o_cs_b(cs_b),
        .o_cs_c(cs_c), .o_rnw(rnw), .o_register_select(register_select), .o_strobe(strb));

    ucr_uart_top #(.CLKS_PER_BIT(CPB)) ucr_uart_top_inst (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_tx_bus(tx_bus), .i_chip_sel_a(cs_a), .i_chip_sel_b(cs_b), .i_chip_sel_c(cs_c),
        .i_read_not_write(rnw), .i_register_select(register_select), .i_write_strobe(strb), .i_clear_b(clear_b),
        .i_cts_b(cts_b), .i_ser_clk(ser_clk), .i_periph_status_irq_b(psi_b), .i_rx_char_ready(rx_rdy),
        .i_rx_parity_fail(rx_pfail), .o_serial_out(so), .o_rts_b(rts_b), .o_holding_reg_empty_b(hre_b),
        .o_shift_reg_empty(sre), .o_int_b(int_b), .o_parity_error(perr), .o_rx_format(rxf));

    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_fmt(input string n, input logic [4:0] e, input logic [4:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Frame spacing allows seven reference cycles of slack either way for synchroniser and load latency.
    task automatic chk_cnt(input string n, input int e, input int g);
        checked++;
        if (g < e - 7 || g > e + 7) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic wait_so(input int lim, output int n);
        for (n = 0; n < lim && so !== 1'b1; n++) @(negedge clk);
    endtask

    task automatic ctl_test();
        ucr_host_model_inst.write(1'b1, 8'h1a);
        chk_fmt("rx_format", 5'h1a, rxf);
        chk_bit("rts_b", 1'b1, rts_b);
        ucr_host_model_inst.write(1'b1, 8'h85);
        chk_fmt("rx_format", 5'h1a, rxf);
        chk_bit("rts_b", 1'b0, rts_b);
        chk_bit("int_b", 1'b1, int_b);
        ucr_host_model_inst.write(1'b1, 8'h3a);
        chk_bit("rts_b", 1'b1, rts_b);
        ucr_host_model_inst.write(1'b1, 8'h80);
        chk_bit("int_b", 1'b0, int_b);
        ucr_host_model_inst.write(1'b1, 8'h1a);
        chk_bit("int_b", 1'b1, int_b);
        rx_pfail = 1'b1;
        repeat (4) @(negedge clk);
        chk_bit("parity_error", 1'b1, perr);
        ucr_host_model_inst.write(1'b1, 8'h1b);
        chk_bit("parity_error", 1'b0, perr);
        rx_pfail = 1'b0;
        // Clear drops every pending flag, so each source below is seen on its own.
        clear_b = 1'b0;
        repeat (4) @(negedge clk);
        clear_b = 1'b1;
        ucr_host_model_inst.write(1'b1, 8'h20);
        chk_bit("int_b", 1'b1, int_b);
        rx_rdy = 1'b1;
        repeat (2) @(negedge clk);
        chk_bit("int_b", 1'b0, int_b);
        rx_rdy = 1'b0;
        psi_b = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit("int_b", 1'b0, int_b);
        psi_b = 1'b1;
        ucr_host_model_inst.write(1'b1, 8'h00);
        chk_bit("int_b", 1'b1, int_b);
    endtask

    task automatic frame(input logic [7:0] ctl, input logic [7:0] d);
        int n;
        int p;
        int f;
        int g;
        int len;
        logic [7:0] m;
        n = 5 + ctl[4:3];
        p = ctl[0] ? 0 : 1;
        m = 8'hff >> (8 - n);
        len = (1 + n + p) * BIT + (!ctl[2] ? 2 : (n == 5 ? 3 : 4)) * BIT / 2;
        ucr_host_model_inst.write(1'b1, ctl);
        line_q.delete();
        rec = 1'b1;
        ucr_host_model_inst.write(1'b0, d);
        for (g = 0; g < 100 && hre_b !== 1'b0; g++) @(negedge clk);
        chk_bit("holding_empty_b", 1'b0, hre_b);
        ucr_host_model_inst.write(1'b0, ~d);
        chk_bit("holding_full_b", 1'b1, hre_b);
        chk_bit("shift_empty", 1'b0, sre);
        for (g = 0; g < 3000 && !(sre === 1'b1 && hre_b === 1'b0); g++) @(negedge clk);
        chk_bit("tx_finished", 1'b1, sre === 1'b1 && hre_b === 1'b0);
        rec = 1'b0;
        f = 0;
        while (f < line_q.size() - 1 && line_q[f] !== 1'b0) f++;
        chk_bit("start", 1'b0, line_q[f + BIT / 2]);
        for (g = 0; g < n; g++) chk_bit("data", d[g], line_q[f + BIT / 2 + (g + 1) * BIT]);
        if (p == 1) chk_bit("parity", ctl[1] ? ^(d & m) : ~^(d & m), line_q[f + BIT / 2 + (n + 1) * BIT]);
        chk_bit("stop", 1'b1, line_q[f + BIT / 2 + (n + p + 1) * BIT]);
        g = f + len - BIT / 2;
        while (g < line_q.size() - 1 && line_q[g] !== 1'b0) g++;
        chk_cnt("frame_len", len, g - f);
    endtask

    task automatic brk(input int mode);
        int n;
        ucr_host_model_inst.write(1'b1, 8'h41);
        repeat (64) @(negedge clk);
        chk_bit("break", 1'b0, so);
        ucr_host_model_inst.write(1'b1, 8'h01);
        repeat (64) @(negedge clk);
        chk_bit("after_break", 1'b0, so);
        if (mode == 0) cts_b = 1'b1;
        if (mode == 1) ucr_host_model_inst.write(1'b0, 8'h00);
        if (mode == 2) clear_b = 1'b0;
        wait_so(mode == 1 ? 600 : 12, n);
        chk_bit("released", 1'b1, so);
        if (mode == 1) chk_bit("zero_word_low", 1'b1, n >= 5 * BIT);
        if (mode == 2) chk_fmt("rx_format", 5'h00, rxf);
        cts_b = 1'b0;
        clear_b = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    task automatic test_done();
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk_bit("serial_out", 1'b1, so);
        chk_bit("rts_b", 1'b1, rts_b);
        chk_bit("int_b", 1'b1, int_b);
        chk_fmt("rx_format", 5'h00, rxf);
        ctl_test();
        for (k = 0; k < 8; k++) frame(CTL_TAB[k], DAT_TAB[k]);
        for (k = 0; k < 3; k++) brk(k);
        test_done();
    end
endmodule
`default_nettype wire
